/* rtl/acr_pkg.sv */
// constants and carrier types for the converter configuration bank
// assumes a plain strobe register port on a single 100 MHz clock
package acr_pkg;
   localparam logic [7:0] ACR_RATE_MODE_OFS = 8'h01;
   localparam logic [7:0] ACR_REF_FILT_OFS = 8'h02;
   localparam logic [7:0] ACR_RATE_MODE_RST = 8'h00;
   localparam logic [7:0] ACR_REF_FILT_RST = 8'h00;
   localparam int ACR_RATE_MSB = 7;
   localparam int ACR_RATE_LSB = 5;
   localparam int ACR_MODE_MSB = 4;
   localparam int ACR_MODE_LSB = 3;
   localparam int ACR_CONT_BIT = 2;
   localparam int ACR_TEMP_BIT = 1;
   localparam int ACR_BURN_BIT = 0;
   localparam int ACR_REF_MSB = 7;
   localparam int ACR_REF_LSB = 6;
   localparam int ACR_FILT_MSB = 5;
   localparam int ACR_FILT_LSB = 4;
   localparam int ACR_SW_BIT = 3;
   localparam int ACR_CUR_MSB = 2;
   localparam int ACR_CUR_LSB = 0;
   // nominal converter clock in kHz; scaled_rate_centi_o scales with the actual clock, rate_centi_sps does not
   localparam logic [15:0] ACR_NOM_CLK_KHZ = 16'h1000;
   localparam logic [2:0] ACR_RATE_RSVD = 3'h7;
   localparam logic [2:0] ACR_CUR_RSVD = 3'h1;

   typedef enum logic [1:0] {
      ACR_MODE_NORMAL = 2'h0,
      ACR_MODE_DUTY = 2'h1,
      ACR_MODE_TURBO = 2'h2,
      ACR_MODE_RSVD = 2'h3
   } acr_mode_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } acr_bus_req_type;

   typedef struct packed {
      logic [15:0] rate_centi_sps; // output rate in 0.01 SPS
      logic rate_valid;
      logic duty_cycle;
      logic turbo_mod_clk;
      logic continuous_conv_sel;
      logic temp_sensor_en;
      logic mux_gain_override;
      logic burnout_src_en;
      logic [1:0] ref_sel;
      logic [1:0] reject_sel;
      logic [2:0] excitation_current_sel;
      logic [10:0] excitation_ua;
      logic cur_valid;
   } acr_cfg_type;
endpackage

/* rtl/acr_config_regs.sv */
// configuration registers one and two with decoded converter controls
// assumes the host keeps the rejection field zero except at slowest rates
`timescale 1ns/100ps
module acr_config_regs (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire acr_pkg::acr_bus_req_type bus_i,
   input wire logic start_cmd_i,
   input wire logic sleep_cmd_i,
   input wire logic [15:0] ext_clk_khz_i,
   input wire logic ext_clk_sel_i,
   output logic [7:0] rdata_o,
   output acr_pkg::acr_cfg_type cfg_o,
   output logic low_side_switch_closed_o,
   output logic [31:0] scaled_rate_centi_o
);
   logic [7:0] rate_mode_config_q;
   logic [7:0] reference_filter_current_config_q;
   logic [7:0] rdata_q;
   logic sw_q;
   logic [31:0] scaled_q;
   wire hit1 = bus_i.addr == acr_pkg::ACR_RATE_MODE_OFS;
   wire hit2 = bus_i.addr == acr_pkg::ACR_REF_FILT_OFS;
   wire [2:0] output_rate_sel =
      rate_mode_config_q[acr_pkg::ACR_RATE_MSB:acr_pkg::ACR_RATE_LSB];
   wire [1:0] mode_sel =
      rate_mode_config_q[acr_pkg::ACR_MODE_MSB:acr_pkg::ACR_MODE_LSB];
   wire low_side_switch_auto =
      reference_filter_current_config_q[acr_pkg::ACR_SW_BIT];
   wire [2:0] excitation_current_sel =
      reference_filter_current_config_q[acr_pkg::ACR_CUR_MSB:
                                        acr_pkg::ACR_CUR_LSB];
   wire [7:0] rd_mux = hit1 ? rate_mode_config_q :
      hit2 ? reference_filter_current_config_q : 8'h00;
   logic [15:0] rate_c;
   logic [10:0] cur_c;
   wire [15:0] clk_khz = ext_clk_sel_i ? ext_clk_khz_i :
      acr_pkg::ACR_NOM_CLK_KHZ;

   // writes store any code, reserved ones too
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rate_mode_config_q <= acr_pkg::ACR_RATE_MODE_RST;
         reference_filter_current_config_q <= acr_pkg::ACR_REF_FILT_RST;
      end else if (bus_i.wr) begin
         if (hit1) begin
            rate_mode_config_q <= bus_i.wdata;
         end
         if (hit2) begin
            reference_filter_current_config_q <= bus_i.wdata;
         end
      end
   end

   // unmapped offsets read zero
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rdata_q <= 8'h00;
      end else if (bus_i.rd) begin
         rdata_q <= rd_mux;
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign rdata_o = rdata_q;

   // rate table in hundredths of SPS; zero marks a reserved code
   always_comb begin
      rate_c = 16'h0000;
      case (mode_sel)
         2'h0: begin
            case (output_rate_sel)
               3'h0: rate_c = 16'h07D0;
               3'h1: rate_c = 16'h1194;
               3'h2: rate_c = 16'h2328;
               3'h3: rate_c = 16'h445C;
               3'h4: rate_c = 16'h80E8;
               3'h5: rate_c = 16'hEA60;
               default: rate_c = 16'h0000;
            endcase
            if (output_rate_sel == 3'h6) begin
               rate_c = 16'hFFFF; // 1000 SPS exceeds the field, see wide path
            end
         end
         2'h1: begin
            case (output_rate_sel)
               3'h0: rate_c = 16'h01F4;
               3'h1: rate_c = 16'h0465;
               3'h2: rate_c = 16'h08CA;
               3'h3: rate_c = 16'h1130;
               3'h4: rate_c = 16'h203A;
               3'h5: rate_c = 16'h3A98;
               3'h6: rate_c = 16'h61A8;
               default: rate_c = 16'h0000;
            endcase
         end
         2'h2: begin
            case (output_rate_sel)
               3'h0: rate_c = 16'h0FA0;
               3'h1: rate_c = 16'h2328;
               3'h2: rate_c = 16'h4650;
               3'h3: rate_c = 16'h88B8;
               default: rate_c = 16'hFFFF;
            endcase
            if (output_rate_sel == acr_pkg::ACR_RATE_RSVD) begin
               rate_c = 16'h0000;
            end
         end
         default: rate_c = 16'h0000;
      endcase
   end

   // exact wide rate in hundredths of SPS for the nominal clock
   logic [31:0] wide_c;
   always_comb begin
      wide_c = {16'h0000, rate_c};
      if (mode_sel == 2'h0 && output_rate_sel == 3'h6) begin
         wide_c = 32'h000186A0;
      end
      if (mode_sel == 2'h2) begin
         case (output_rate_sel)
            3'h4: wide_c = 32'h000101D0;
            3'h5: wide_c = 32'h0001D4C0;
            3'h6: wide_c = 32'h00030D40;
            default: wide_c = {16'h0000, rate_c};
         endcase
      end
   end

   // proportional scaling with the converter clock
   wire [47:0] prod = {16'h0000, wide_c} * {32'h00000000, clk_khz};
   wire [47:0] quot = prod / {32'h00000000, acr_pkg::ACR_NOM_CLK_KHZ};
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         scaled_q <= 32'h00000000;
      end else begin
         scaled_q <= quot[31:0];
      end
   end
   assign scaled_rate_centi_o = scaled_q;

   always_comb begin
      case (excitation_current_sel)
         3'h2: cur_c = 11'd50;
         3'h3: cur_c = 11'd100;
         3'h4: cur_c = 11'd250;
         3'h5: cur_c = 11'd500;
         3'h6: cur_c = 11'd1000;
         3'h7: cur_c = 11'd1500;
         default: cur_c = 11'd0;
      endcase
   end

   // switch closes on start, opens on sleep or when auto mode is off
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sw_q <= 1'b0;
      end else if (!low_side_switch_auto || sleep_cmd_i) begin
         sw_q <= 1'b0;
      end else if (start_cmd_i) begin
         sw_q <= 1'b1;
      end
   end
   assign low_side_switch_closed_o = sw_q;

   always_comb begin
      cfg_o.rate_centi_sps = rate_c;
      cfg_o.rate_valid = output_rate_sel != acr_pkg::ACR_RATE_RSVD &&
         mode_sel != 2'h3;
      cfg_o.duty_cycle = mode_sel == 2'h1;
      cfg_o.turbo_mod_clk = mode_sel == 2'h2;
      cfg_o.continuous_conv_sel =
         rate_mode_config_q[acr_pkg::ACR_CONT_BIT];
      cfg_o.temp_sensor_en = rate_mode_config_q[acr_pkg::ACR_TEMP_BIT];
      // temperature mode forces the internal reference
      cfg_o.mux_gain_override = cfg_o.temp_sensor_en;
      cfg_o.ref_sel = cfg_o.temp_sensor_en ? 2'h0 :
         reference_filter_current_config_q[acr_pkg::ACR_REF_MSB:
                                           acr_pkg::ACR_REF_LSB];
      cfg_o.burnout_src_en = rate_mode_config_q[acr_pkg::ACR_BURN_BIT];
      cfg_o.reject_sel =
         reference_filter_current_config_q[acr_pkg::ACR_FILT_MSB:
                                           acr_pkg::ACR_FILT_LSB];
      cfg_o.excitation_current_sel = excitation_current_sel;
      cfg_o.excitation_ua = cur_c;
      cfg_o.cur_valid = excitation_current_sel != acr_pkg::ACR_CUR_RSVD;
   end

   AST_RST1: assert property (@(posedge clk_i) reset_i |=>
      rate_mode_config_q == 8'h00) else $error("reg1 not zero after reset");
   AST_RST2: assert property (@(posedge clk_i) reset_i |=>
      reference_filter_current_config_q == 8'h00)
      else $error("reg2 not zero after reset");
   AST_WR1: assert property (@(posedge clk_i) disable iff (reset_i)
      bus_i.wr && hit1 |=> rate_mode_config_q == $past(bus_i.wdata))
      else $error("reg1 write lost");
   AST_RD2: assert property (@(posedge clk_i) disable iff (reset_i)
      bus_i.wr && hit2 ##1 bus_i.rd && hit2 && !bus_i.wr |=>
      rdata_o == $past(bus_i.wdata, 2)) else $error("reg2 readback wrong");
   AST_SW: assert property (@(posedge clk_i) disable iff (reset_i)
      sleep_cmd_i |=> !low_side_switch_closed_o)
      else $error("switch not opened by sleep");
   AST_SWC: assert property (@(posedge clk_i) disable iff (reset_i)
      start_cmd_i && !sleep_cmd_i && low_side_switch_auto |=>
      low_side_switch_closed_o) else $error("switch not closed by start");
   AST_TS: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[1] |-> cfg_o.ref_sel == 2'h0 &&
      cfg_o.mux_gain_override) else $error("temp mode reference wrong");
   AST_RATE: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h00 && !ext_clk_sel_i ##1 1'b1 |->
      scaled_q == 32'h000007D0) else $error("20 SPS rate wrong");
   AST_CUR: assert property (@(posedge clk_i) disable iff (reset_i)
      excitation_current_sel == 3'h7 |-> cfg_o.excitation_ua == 11'd1500)
      else $error("excitation current wrong");

   // rate table checks at the nominal clock, one per code and mode
   AST_RN1: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h04 && !ext_clk_sel_i |=>
      scaled_q == 32'h00001194) else $error("normal rate 1 wrong");
   AST_RN2: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h08 && !ext_clk_sel_i |=>
      scaled_q == 32'h00002328) else $error("normal rate 2 wrong");
   AST_RN3: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h0C && !ext_clk_sel_i |=>
      scaled_q == 32'h0000445C) else $error("normal rate 3 wrong");
   AST_RN4: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h10 && !ext_clk_sel_i |=>
      scaled_q == 32'h000080E8) else $error("normal rate 4 wrong");
   AST_RN5: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h14 && !ext_clk_sel_i |=>
      scaled_q == 32'h0000EA60) else $error("normal rate 5 wrong");
   AST_RN6: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h18 && !ext_clk_sel_i |=>
      scaled_q == 32'h000186A0) else $error("normal rate 6 wrong");
   AST_RDC0: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h01 && !ext_clk_sel_i |=>
      scaled_q == 32'h000001F4) else $error("duty rate 0 wrong");
   AST_RDC1: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h05 && !ext_clk_sel_i |=>
      scaled_q == 32'h00000465) else $error("duty rate 1 wrong");
   AST_RDC2: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h09 && !ext_clk_sel_i |=>
      scaled_q == 32'h000008CA) else $error("duty rate 2 wrong");
   AST_RDC3: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h0D && !ext_clk_sel_i |=>
      scaled_q == 32'h00001130) else $error("duty rate 3 wrong");
   AST_RDC4: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h11 && !ext_clk_sel_i |=>
      scaled_q == 32'h0000203A) else $error("duty rate 4 wrong");
   AST_RDC5: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h15 && !ext_clk_sel_i |=>
      scaled_q == 32'h00003A98) else $error("duty rate 5 wrong");
   AST_RDC6: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h19 && !ext_clk_sel_i |=>
      scaled_q == 32'h000061A8) else $error("duty rate 6 wrong");
   AST_RT0: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h02 && !ext_clk_sel_i |=>
      scaled_q == 32'h00000FA0) else $error("turbo rate 0 wrong");
   AST_RT1: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h06 && !ext_clk_sel_i |=>
      scaled_q == 32'h00002328) else $error("turbo rate 1 wrong");
   AST_RT2: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h0A && !ext_clk_sel_i |=>
      scaled_q == 32'h00004650) else $error("turbo rate 2 wrong");
   AST_RT3: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h0E && !ext_clk_sel_i |=>
      scaled_q == 32'h000088B8) else $error("turbo rate 3 wrong");
   AST_RT4: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h12 && !ext_clk_sel_i |=>
      scaled_q == 32'h000101D0) else $error("turbo rate 4 wrong");
   AST_RT5: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h16 && !ext_clk_sel_i |=>
      scaled_q == 32'h0001D4C0) else $error("turbo rate 5 wrong");
   AST_RT6: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h1A && !ext_clk_sel_i |=>
      scaled_q == 32'h00030D40) else $error("turbo rate 6 wrong");
   // reserved codes give a zero rate so software can spot them
   AST_RRSV: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:5] == 3'h7 |=> scaled_q == 32'h00000000)
      else $error("reserved rate code not zero");
   AST_MRSV: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[4:3] == 2'h3 |=> scaled_q == 32'h00000000)
      else $error("reserved mode rate not zero");
   AST_MVAL: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[4:3] == 2'h3 |-> !cfg_o.rate_valid)
      else $error("reserved mode flagged valid");
   AST_MDUTY: assert property (@(posedge clk_i) disable iff (reset_i)
      cfg_o.duty_cycle == (rate_mode_config_q[4:3] == 2'h1))
      else $error("duty-cycle flag wrong");
   AST_MTURBO: assert property (@(posedge clk_i) disable iff (reset_i)
      cfg_o.turbo_mod_clk == (rate_mode_config_q[4:3] == 2'h2))
      else $error("turbo flag wrong");
   AST_HALF: assert property (@(posedge clk_i) disable iff (reset_i)
      rate_mode_config_q[7:3] == 5'h00 && ext_clk_sel_i &&
      ext_clk_khz_i == 16'h0800 |=> scaled_q == 32'h000003E8)
      else $error("half clock rate wrong");
   AST_CONT: assert property (@(posedge clk_i) disable iff (reset_i)
      cfg_o.continuous_conv_sel == rate_mode_config_q[2])
      else $error("conversion mode wrong");
   AST_BURN: assert property (@(posedge clk_i) disable iff (reset_i)
      cfg_o.burnout_src_en == rate_mode_config_q[0])
      else $error("burn-out enable wrong");
   AST_REF: assert property (@(posedge clk_i) disable iff (reset_i)
      !rate_mode_config_q[1] |->
      cfg_o.ref_sel == reference_filter_current_config_q[7:6])
      else $error("reference select wrong");
   AST_FILT: assert property (@(posedge clk_i) disable iff (reset_i)
      cfg_o.reject_sel == reference_filter_current_config_q[5:4])
      else $error("rejection select wrong");
   AST_CURV: assert property (@(posedge clk_i) disable iff (reset_i)
      cfg_o.cur_valid == (excitation_current_sel != 3'h1))
      else $error("current valid flag wrong");
   AST_CUR0: assert property (@(posedge clk_i) disable iff (reset_i)
      excitation_current_sel == 3'h0 |-> cfg_o.excitation_ua == 11'd0)
      else $error("current off wrong");
   AST_CUR1: assert property (@(posedge clk_i) disable iff (reset_i)
      excitation_current_sel == 3'h1 |-> cfg_o.excitation_ua == 11'd0)
      else $error("reserved current not zero");
   AST_CUR2: assert property (@(posedge clk_i) disable iff (reset_i)
      excitation_current_sel == 3'h2 |-> cfg_o.excitation_ua == 11'd50)
      else $error("current 50 wrong");
   AST_CUR3: assert property (@(posedge clk_i) disable iff (reset_i)
      excitation_current_sel == 3'h3 |-> cfg_o.excitation_ua == 11'd100)
      else $error("current 100 wrong");
   AST_CUR4: assert property (@(posedge clk_i) disable iff (reset_i)
      excitation_current_sel == 3'h4 |-> cfg_o.excitation_ua == 11'd250)
      else $error("current 250 wrong");
   AST_CUR5: assert property (@(posedge clk_i) disable iff (reset_i)
      excitation_current_sel == 3'h5 |-> cfg_o.excitation_ua == 11'd500)
      else $error("current 500 wrong");
   AST_CUR6: assert property (@(posedge clk_i) disable iff (reset_i)
      excitation_current_sel == 3'h6 |-> cfg_o.excitation_ua == 11'd1000)
      else $error("current 1000 wrong");
   // read port: one-cycle data, zero otherwise
   AST_RD1: assert property (@(posedge clk_i) disable iff (reset_i)
      bus_i.rd && hit1 && !bus_i.wr |=>
      rdata_o == $past(rate_mode_config_q)) else $error("reg1 read wrong");
   AST_RDZ: assert property (@(posedge clk_i) disable iff (reset_i)
      bus_i.rd && !hit1 && !hit2 |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   AST_IDLE: assert property (@(posedge clk_i) disable iff (reset_i)
      !bus_i.rd |=> rdata_o == 8'h00) else $error("read data not cleared");
   AST_RST3: assert property (@(posedge clk_i) reset_i |=>
      scaled_q == 32'h00000000) else $error("rate not zero after reset");
   AST_SWO: assert property (@(posedge clk_i) disable iff (reset_i)
      !low_side_switch_auto |=> !low_side_switch_closed_o)
      else $error("switch closed without auto mode");
endmodule

/* verification/acr_host_model.sv */
// host controller model that owns the register port of the bank
// assumes one clock; the bench calls its tasks once reset is released
`timescale 1ns/100ps
module acr_host_model (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output acr_pkg::acr_bus_req_type bus_o
);
   initial bus_o = '0;

   // each access starts on a fresh edge so no strobe is assigned twice
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      bus_o <= '0;
   endtask

   // write then read with no idle cycle between the strobes
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] w,
      output logic [7:0] d);
      @(posedge clk_i);
      bus_o <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      bus_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      bus_o <= '0;
      #1;
      d = rdata_i;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      bus_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      bus_o <= '0;
      #1;
      d = rdata_i;
   endtask
endmodule

/* verification/adc_config_regs_one_two_tb.sv */
// self-checking bench for the two converter configuration registers
// assumes the host model above and fixed one- and two-cycle latencies
`timescale 1ns/100ps
module adc_config_regs_one_two_tb;
   logic clk_i = 0, reset_i = 1, start_cmd_i = 0, sleep_cmd_i = 0;
   logic ext_clk_sel_i = 0;
   logic [15:0] ext_clk_khz_i = 16'h1000;
   logic [7:0] rdata_o, rd_v;
   logic low_side_switch_closed_o;
   logic [31:0] scaled_rate_centi_o;
   acr_pkg::acr_bus_req_type bus;
   acr_pkg::acr_cfg_type cfg_o;
   int err_total = 0, check_count = 0;
   int rate_tab [3][7] = '{'{2000, 4500, 9000, 17500, 33000, 60000, 100000},
      '{500, 1125, 2250, 4400, 8250, 15000, 25000},
      '{4000, 9000, 18000, 35000, 66000, 120000, 200000}};
   int cur_tab [8] = '{0, 0, 50, 100, 250, 500, 1000, 1500};

   acr_host_model host_u (.clk_i(clk_i), .rdata_i(rdata_o), .bus_o(bus));
   acr_config_regs dut_u (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus),
      .start_cmd_i(start_cmd_i), .sleep_cmd_i(sleep_cmd_i),
      .ext_clk_khz_i(ext_clk_khz_i), .ext_clk_sel_i(ext_clk_sel_i),
      .rdata_o(rdata_o), .cfg_o(cfg_o),
      .low_side_switch_closed_o(low_side_switch_closed_o),
      .scaled_rate_centi_o(scaled_rate_centi_o));

   initial forever #5 clk_i = ~clk_i;

   task automatic report_and_stop;
      if (err_total == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // waits out the registered rate scaling before anything is compared
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      host_u.wr_reg(a, d);
      repeat (2) @(posedge clk_i);
      #1;
   endtask

   task automatic pulse(input logic st, input logic sp);
      @(posedge clk_i);
      start_cmd_i <= st;
      sleep_cmd_i <= sp;
      @(posedge clk_i);
      start_cmd_i <= 1'b0;
      sleep_cmd_i <= 1'b0;
      #1;
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      report_and_stop();
   end

   initial begin
      repeat (20) @(posedge clk_i);
      reset_i <= 1'b0;
      host_u.rd_reg(8'h01, rd_v); chk("reg1", 8'h00, rd_v);
      host_u.rd_reg(8'h02, rd_v); chk("reg2", 8'h00, rd_v);
      host_u.rd_reg(8'h03, rd_v); chk("unmapped", 8'h00, rd_v);
      for (int m = 0; m < 3; m++) begin
         for (int r = 0; r < 8; r++) begin
            put(8'h01, 8'(r * 32 + m * 8));
            chk("rate", (r == 7) ? 0 : rate_tab[m][r], scaled_rate_centi_o);
            chk("rate ok", 32'(r != 7), 32'(cfg_o.rate_valid));
            chk("mode", {m == 2, m == 1}, {cfg_o.turbo_mod_clk, cfg_o.duty_cycle});
            host_u.rd_reg(8'h01, rd_v); chk("reg1", r * 32 + m * 8, rd_v);
         end
      end
      // reserved codes and a stray write to an unmapped offset
      put(8'h01, 8'hF8);
      chk("rsvd rate", 0, scaled_rate_centi_o);
      chk("rsvd ok", 0, 32'(cfg_o.rate_valid));
      put(8'h03, 8'h00);
      host_u.rd_reg(8'h01, rd_v); chk("reserved", 8'hF8, rd_v);
      put(8'h01, 8'h18);
      chk("rsvd mode", 0, scaled_rate_centi_o);
      chk("rsvd mode ok", 0, 32'(cfg_o.rate_valid));
      @(posedge clk_i);
      ext_clk_sel_i <= 1'b1;
      ext_clk_khz_i <= 16'h0800;
      put(8'h01, 8'h00); chk("half clk", 1000, scaled_rate_centi_o);
      put(8'h01, 8'hD0); chk("half turbo", 100000, scaled_rate_centi_o);
      put(8'h02, 8'hC0);
      put(8'h01, 8'h07);
      chk("bits", 3'h7, {cfg_o.continuous_conv_sel, cfg_o.temp_sensor_en, cfg_o.burnout_src_en});
      chk("temp", 3'h4, {cfg_o.mux_gain_override, cfg_o.ref_sel});
      put(8'h01, 8'h00);
      chk("bits", 3'h0, {cfg_o.continuous_conv_sel, cfg_o.temp_sensor_en, cfg_o.burnout_src_en});
      for (int v = 0; v < 4; v++) begin
         // rejection only written while the slowest normal rate is set
         put(8'h02, 8'(v * 64 + v * 16));
         chk("ref", v, cfg_o.ref_sel);
         chk("reject", v, cfg_o.reject_sel);
      end
      for (int c = 0; c < 8; c++) begin
         put(8'h02, 8'(c));
         chk("cur ok", 32'(c != 1), 32'(cfg_o.cur_valid));
         if (c != 1) chk("cur", cur_tab[c], cfg_o.excitation_ua);
         host_u.rd_reg(8'h02, rd_v); chk("reg2", c, rd_v);
      end
      put(8'h02, 8'h08);
      pulse(1'b1, 1'b0); chk("switch", 1, low_side_switch_closed_o);
      pulse(1'b1, 1'b1); chk("sleep wins", 0, low_side_switch_closed_o);
      pulse(1'b1, 1'b0); chk("switch", 1, low_side_switch_closed_o);
      pulse(1'b0, 1'b1); chk("switch", 0, low_side_switch_closed_o);
      put(8'h02, 8'h00);
      pulse(1'b1, 1'b0); chk("switch", 0, low_side_switch_closed_o);
      host_u.wr_rd(8'h02, 8'hA5, rd_v); chk("wr then rd", 8'hA5, rd_v);
      report_and_stop();
   end
endmodule
